//--- hdl/tpb_map.vh
`ifndef TPB_MAP_VH
`define TPB_MAP_VH

// Register byte addresses on the APB port
`define TPB_CH1_CTL_ADDR 12'h000
`define TPB_CH2_CTL_ADDR 12'h004
`define TPB_CH1_GRB_ADDR 12'h008
`define TPB_CH2_GRB_ADDR 12'h00C
`define TPB_STATUS_ADDR 12'h010

// Field positions inside the I/O control byte
`define TPB_BIT_MODE 7
`define TPB_BIT_INIT 6
`define TPB_BIT_ACT_HI 5
`define TPB_BIT_ACT_LO 4

// Reset values
`define TPB_CTL_RESET 8'h00
`define TPB_GRB_RESET 16'h0000

// Output action codes in bits 5:4
`define TPB_ACT_OFF 2'h0
`define TPB_ACT_ZERO 2'h1
`define TPB_ACT_ONE 2'h2
`define TPB_ACT_TOGGLE 2'h3

// Wait states before pready
`define TPB_APB_WAIT 0

`endif

//--- hdl/tpb_chan.v
`timescale 1ns/1ns
`include "tpb_map.vh"

// One channel: pin B compare output or capture of the counter
module tpb_chan #(
    parameter CW = 16,
    parameter HAS_EXT = 0
) (
    // Clock and reset
    input wire i_ref_clk,
    input wire i_rst_n,
    // Control byte and counter
    input wire [7:0] i_ctl,
    input wire [CW-1:0] i_count,
    input wire [CW-1:0] i_grb,
    input wire i_grb_wr,
    input wire [CW-1:0] i_grb_wdata,
    // Pin sample (already synchronised) and external event
    input wire i_pin_sync,
    input wire i_ext_evt,
    // Results
    output reg [CW-1:0] o_grb,
    output reg o_pin,
    output reg o_pin_oe_n,
    output reg o_capt
);
    // Previous pin sample for edge detection
    reg pin_prev_reg;
    // Previous control byte, to see a newly selected output mode
    reg [7:0] ctl_prev_reg;

    wire mode_in = i_ctl[`TPB_BIT_MODE];
    wire [1:0] act = i_ctl[`TPB_BIT_ACT_HI:`TPB_BIT_ACT_LO];
    wire match = (i_count == i_grb);
    wire rise = i_pin_sync & ~pin_prev_reg;
    wire fall = ~i_pin_sync & pin_prev_reg;
    wire ext_sel = (HAS_EXT != 0) && i_ctl[`TPB_BIT_INIT];
    // New output code chosen: drive the initial level
    wire oc_enter = !mode_in && (act != `TPB_ACT_OFF) &&
                    (ctl_prev_reg != i_ctl);
    reg capt_next;

    // Capture source and edge choice
    always @* begin
        capt_next = 1'b0;
        if (mode_in) begin
            if (ext_sel) begin
                capt_next = i_ext_evt;
            end else if (i_ctl[`TPB_BIT_ACT_HI]) begin
                capt_next = rise | fall;
            end else if (i_ctl[`TPB_BIT_ACT_LO]) begin
                capt_next = fall;
            end else begin
                capt_next = rise;
            end
        end
    end

    // Register B: software write, capture load
    always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_grb <= `TPB_GRB_RESET;
            o_capt <= 1'b0;
            pin_prev_reg <= 1'b0;
            ctl_prev_reg <= `TPB_CTL_RESET;
        end else begin
            pin_prev_reg <= i_pin_sync;
            ctl_prev_reg <= i_ctl;
            o_capt <= capt_next;
            if (capt_next) begin
                o_grb <= i_count;
            end else if (i_grb_wr) begin
                o_grb <= i_grb_wdata;
            end
        end
    end

    // Pin driver in output compare mode
    always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_pin <= 1'b0;
            o_pin_oe_n <= 1'b1;
        end else if (mode_in || act == `TPB_ACT_OFF) begin
            o_pin_oe_n <= 1'b1;
        end else begin
            o_pin_oe_n <= 1'b0;
            if (oc_enter) begin
                o_pin <= i_ctl[`TPB_BIT_INIT];
            end else if (match) begin
                case (act)
                    `TPB_ACT_ZERO: o_pin <= 1'b0;
                    `TPB_ACT_ONE: o_pin <= 1'b1;
                    `TPB_ACT_TOGGLE: o_pin <= ~o_pin;
                    default: o_pin <= o_pin;
                endcase
            end
        end
    end
endmodule // tpb_chan

//--- hdl/tpb_top.v
`timescale 1ns/1ns
`include "tpb_map.vh"

// Functional notes
// - Bit7 clear: compare; 00 off, 01 drive 0
// - Code 10 drives pin high on match
// - Code 11 toggles pin on match
// - Code 1000 captures on rising pin edge
// - Code 1001 captures on falling pin edge
// - Code 101X captures on both edges
// - Channel 1 code 11XX captures on ch0 C event
module tpb_top #(
    parameter CW = 16
) (
    // Clock and reset
    input wire i_ref_clk,
    input wire i_rst_n,
    // APB slave
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [11:0] i_paddr,
    input wire [31:0] i_pwdata,
    output reg [31:0] o_prdata,
    output reg o_pready,
    output reg o_pslverr,
    // Shared counter and channel zero C event
    input wire [CW-1:0] i_count,
    input wire i_ch0_grc_evt,
    // Channel 1 pin B
    input wire i_ch1_pin_b,
    output wire o_ch1_pin_b,
    output wire o_ch1_pin_b_oe_n,
    // Channel 2 pin B
    input wire i_ch2_pin_b,
    output wire o_ch2_pin_b,
    output wire o_ch2_pin_b_oe_n
);
    // Control registers: bit 7 picks capture or compare, bit 6 the
    // initial level or the channel zero source, bits 5:4 the action
    // or the capture edge.
    reg [7:0] ch1_io_control_reg; // Channel 1 pin B control byte
    reg [7:0] ch2_io_control_reg; // Channel 2 pin B control byte
    // Capture flags, sticky until status read
    reg [1:0] capt_seen_reg; // Bit 0 channel 1, bit 1 channel 2
    // Pin synchronisers, three stages each; stage 0 meets the pin,
    // only stage 1 reads it, and stages 1 and 2 vote on the level.
    reg [2:0] ch1_sync_reg; // Channel 1 pin shift chain
    reg [2:0] ch2_sync_reg; // Channel 2 pin shift chain
    reg ch1_pin_reg; // Channel 1 agreed pin level
    reg ch2_pin_reg; // Channel 2 agreed pin level
    // Channel outputs; register B lives inside each channel so that a
    // capture and a software write are settled in one place.
    wire [CW-1:0] ch1_general_reg_b; // Channel 1 register B
    wire [CW-1:0] ch2_general_reg_b; // Channel 2 register B
    wire ch1_capt; // Channel 1 captured last edge
    wire ch2_capt; // Channel 2 captured last edge
    // Bus access decode. An access phase is taken once, on the edge
    // where psel and penable are high and no answer is out yet; the
    // answer cycle is masked, so a master that still holds its request
    // while it samples pready is not served twice.
    wire acc = i_psel & i_penable & ~o_pready; // Access taken
    wire wr = acc & i_pwrite; // Write taken
    wire rd = acc & ~i_pwrite; // Read taken
    // Capture pulses of both channels, channel 1 in bit 0
    wire [1:0] capt_now = {ch2_capt, ch1_capt};
    // Status word: capture flags low, the two driven pin levels above;
    // bit 2 is the channel 1 pin and bit 3 the channel 2 pin
    wire [31:0] status_word = {28'h0000000, o_ch2_pin_b, o_ch1_pin_b,
                               capt_seen_reg};

    // Known address check: the five word addresses of the map; any
    // other address, unaligned ones too, answers with an error
    function addr_ok;
        input [11:0] a;
        begin
            addr_ok = (a == `TPB_CH1_CTL_ADDR) || (a == `TPB_CH2_CTL_ADDR) ||
                      (a == `TPB_CH1_GRB_ADDR) || (a == `TPB_CH2_GRB_ADDR) ||
                      (a == `TPB_STATUS_ADDR);
        end
    endfunction

    // Strobe for one register: a taken access to its exact address.
    // Partial or unaligned matches never reach a register.
    function acc_hit;
        input strobe;
        input [11:0] a;
        input [11:0] target;
        begin
            acc_hit = strobe && (a == target);
        end
    endfunction

    // Per-register strobes, one for each register that bus access changes
    wire ch1_ctl_wr = acc_hit(wr, i_paddr, `TPB_CH1_CTL_ADDR);
    wire ch2_ctl_wr = acc_hit(wr, i_paddr, `TPB_CH2_CTL_ADDR);
    wire ch1_grb_wr = acc_hit(wr, i_paddr, `TPB_CH1_GRB_ADDR);
    wire ch2_grb_wr = acc_hit(wr, i_paddr, `TPB_CH2_GRB_ADDR);
    wire status_rd = acc_hit(rd, i_paddr, `TPB_STATUS_ADDR);

    // Pin synchronisers; level counts once stages two and three agree.
    // The pins change with no regard for this clock, so the first stage
    // may go metastable; the vote also drops a one-cycle glitch, at the
    // cost of one more cycle before a capture. The reset level 0 is the
    // idle level of a released pin, so no false edge follows reset.
    always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            // Start at the idle low level
            ch1_sync_reg <= 3'h0;
            ch2_sync_reg <= 3'h0;
            ch1_pin_reg <= 1'b0;
            ch2_pin_reg <= 1'b0;
        end else begin
            // Shift each pin one stage deeper
            ch1_sync_reg <= {ch1_sync_reg[1:0], i_ch1_pin_b};
            ch2_sync_reg <= {ch2_sync_reg[1:0], i_ch2_pin_b};
            // Take a level only once the last two stages agree
            if (ch1_sync_reg[2] == ch1_sync_reg[1]) begin
                ch1_pin_reg <= ch1_sync_reg[2];
            end
            if (ch2_sync_reg[2] == ch2_sync_reg[1]) begin
                ch2_pin_reg <= ch2_sync_reg[2];
            end
        end
    end

    // APB register writes, answer and read data.
    // There are no wait states: the answer leaves one edge after the
    // access phase is taken and stands for that one cycle only. A write
    // lands on the taken edge; read data are launched on it and are
    // zero in every other cycle, so a stale word is never left on the
    // bus. An unmapped address answers with an error, writes nothing
    // and reads zero.
    always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            ch1_io_control_reg <= `TPB_CTL_RESET;
            ch2_io_control_reg <= `TPB_CTL_RESET;
            capt_seen_reg <= 2'h0;
            o_prdata <= 32'h00000000;
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
        end else begin
            // Answer and error flag, one cycle each
            o_pready <= acc;
            o_pslverr <= acc & ~addr_ok(i_paddr);
            // Capture sets win over the read clear, so a capture in the
            // cycle of the status read is reported by the next read
            if (status_rd) begin
                capt_seen_reg <= capt_now; // Clear, keep new sets
            end else begin
                capt_seen_reg <= capt_seen_reg | capt_now; // Collect
            end
            // Control bytes take the low byte of the write data
            if (ch1_ctl_wr) begin
                ch1_io_control_reg <= i_pwdata[7:0];
            end
            if (ch2_ctl_wr) begin
                ch2_io_control_reg <= i_pwdata[7:0];
            end
            // Read data stand only in the answer cycle
            o_prdata <= 32'h00000000;
            if (rd) begin
                case (i_paddr)
                    `TPB_CH1_CTL_ADDR: o_prdata <= {24'h000000,
                                                    ch1_io_control_reg};
                    `TPB_CH2_CTL_ADDR: o_prdata <= {24'h000000,
                                                    ch2_io_control_reg};
                    `TPB_CH1_GRB_ADDR: o_prdata[CW-1:0] <= ch1_general_reg_b;
                    `TPB_CH2_GRB_ADDR: o_prdata[CW-1:0] <= ch2_general_reg_b;
                    `TPB_STATUS_ADDR: o_prdata <= status_word;
                    // Unmapped reads return zero
                    default: o_prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // Limitations: the counter and the channel zero event are trusted
    // to come from this clock. A counter that stops on register B
    // repeats the compare action every cycle, so the toggle code then
    // gives a pin that toggles each cycle.

    // Channel 1 may capture on channel zero C events. The event comes
    // from logic on this clock, so it enters the channel without any
    // synchroniser and is taken in the cycle it is high.
    tpb_chan #(.CW(CW), .HAS_EXT(1)) u_ch1 (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_ctl(ch1_io_control_reg),
        .i_count(i_count),
        .i_grb(ch1_general_reg_b),
        .i_grb_wr(ch1_grb_wr),
        .i_grb_wdata(i_pwdata[CW-1:0]),
        .i_pin_sync(ch1_pin_reg),
        .i_ext_evt(i_ch0_grc_evt),
        .o_grb(ch1_general_reg_b),
        .o_pin(o_ch1_pin_b),
        .o_pin_oe_n(o_ch1_pin_b_oe_n),
        .o_capt(ch1_capt)
    );

    // Channel 2 ignores bit 6 in capture modes. Its event input is tied
    // low: this channel has no channel zero source, and the tie keeps
    // the port from floating.
    tpb_chan #(.CW(CW), .HAS_EXT(0)) u_ch2 (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_ctl(ch2_io_control_reg),
        .i_count(i_count),
        .i_grb(ch2_general_reg_b),
        .i_grb_wr(ch2_grb_wr),
        .i_grb_wdata(i_pwdata[CW-1:0]),
        .i_pin_sync(ch2_pin_reg),
        .i_ext_evt(1'b0),
        .o_grb(ch2_general_reg_b),
        .o_pin(o_ch2_pin_b),
        .o_pin_oe_n(o_ch2_pin_b_oe_n),
        .o_capt(ch2_capt)
    );
endmodule // tpb_top

//--- verification/tpb_pin_model.sv
`timescale 1ns/1ns
// Far side of one pin B line, with a pull-down
module tpb_pin_model (
    // Far-side drive request
    input wire i_drv,
    input wire i_val,
    // Block output and its active low enable
    input wire i_pin,
    input wire i_oe_n,
    // Resolved line level
    output wire o_line
);
    // Block wins when enabled; a released line falls to the pull-down
    assign o_line = !i_oe_n ? i_pin : (i_drv ? i_val : 1'b0);
endmodule // tpb_pin_model

//--- verification/tpb_check_monitor.sv
`timescale 1ns/1ns
// Bus handshake and pin enable watch
module tpb_check #(
    parameter CW = 16
) (
    // Clock and reset
    input wire i_ref_clk,
    input wire i_rst_n,
    // Bus side
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [11:0] i_paddr,
    input wire [31:0] i_pwdata,
    input wire [31:0] o_prdata,
    input wire o_pready,
    input wire o_pslverr,
    // Pin enables
    input wire o_ch1_pin_b_oe_n,
    input wire o_ch2_pin_b_oe_n
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    // Access phase taken
    sequence s_take;
        i_psel && i_penable && !o_pready;
    endsequence
    // Control writes of each channel
    sequence s_ctl1;
        s_take ##0 (i_pwrite && i_paddr == 12'h000);
    endsequence
    sequence s_ctl2;
        s_take ##0 (i_pwrite && i_paddr == 12'h004);
    endsequence
    a_ready_answer: assert property (s_take |=> o_pready)
        else $error("ready missing after access");
    a_ready_pulse: assert property (o_pready |=> !o_pready)
        else $error("ready longer than one cycle");
    a_ready_cause: assert property (o_pready |-> $past(i_penable))
        else $error("ready without access");
    a_err_unmapped: assert property (s_take ##0 i_paddr > 12'h010
        |=> o_pslverr) else $error("no error on unmapped");
    a_err_mapped: assert property (s_take ##0 (i_paddr <= 12'h010 &&
        i_paddr[1:0] == 2'h0) |=> !o_pslverr) else $error("bad error");
    a_data_idle: assert property (!o_pready |-> o_prdata == 32'h0)
        else $error("read data outside answer");
    a_out_enable: assert property (s_ctl1 ##0 (!i_pwdata[7] &&
        i_pwdata[5:4] != 2'h0) |-> ##[1:3] !o_ch1_pin_b_oe_n)
        else $error("output not enabled");
    a_out_off: assert property (s_ctl2 ##0 (i_pwdata[7] ||
        i_pwdata[5:4] == 2'h0) |-> ##[1:3] o_ch2_pin_b_oe_n)
        else $error("output not released");
endmodule // tpb_check

bind tpb_top tpb_check #(.CW(CW)) u_check (.i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_ch1_pin_b_oe_n(o_ch1_pin_b_oe_n),
    .o_ch2_pin_b_oe_n(o_ch2_pin_b_oe_n));

//--- verification/timer_pin_b_io_select_test.sv
`timescale 1ns/1ns
module timer_pin_b_io_select_test;
    reg clk, rst_n, psel, pen, pwr, evt, d1, v1, d2, v2, er;
    reg [11:0] pa;
    reg [31:0] pwd, rd, e;
    reg [15:0] cnt;
    wire [31:0] prd;
    wire rdy, slv, p1, n1, p2, n2, l1, l2;
    integer err_count = 0, samples_checked = 0, i;
    localparam [31:0] CODES = 32'hE090C080; // Rise, rise, fall, both
    tpb_top #(.CW(16)) i_dut (.i_ref_clk(clk), .i_rst_n(rst_n),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa),
        .i_pwdata(pwd), .o_prdata(prd), .o_pready(rdy), .o_pslverr(slv),
        .i_count(cnt), .i_ch0_grc_evt(evt), .i_ch1_pin_b(l1),
        .o_ch1_pin_b(p1), .o_ch1_pin_b_oe_n(n1), .i_ch2_pin_b(l2),
        .o_ch2_pin_b(p2), .o_ch2_pin_b_oe_n(n2));
    tpb_pin_model m1 (.i_drv(d1), .i_val(v1), .i_pin(p1), .i_oe_n(n1),
        .o_line(l1));
    tpb_pin_model m2 (.i_drv(d2), .i_val(v2), .i_pin(p2), .i_oe_n(n2),
        .o_line(l2));
    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // One bus transfer, held until ready is sampled high
    task automatic bus(input w, input [11:0] a, input [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk iff rdy);
        rd = prd;
        er = slv;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    // Compare seen against expected
    task automatic chk(input string n, input [31:0] s, input [31:0] x);
        samples_checked++;
        if (s !== x) begin
            err_count++;
            $display("CHECK FAILED %s exp %h got %h", n, x, s);
        end
    endtask
    // Counts, verdict and end of run
    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        {psel, pen, pwr, pa, pwd, cnt, evt, d1, v1, d2, v2} = 0;
        rst_n = 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        bus(1'b0, 12'h010, 32'h0);
        chk("status", rd, 32'h0);
        bus(1'b0, 12'h020, 32'h0);
        chk("slverr", er, 32'h1);
        chk("badrd", rd, 32'h0);
        bus(1'b1, 12'h008, 32'h40);
        $display("test map done");
        // Every compare code, then one match
        for (i = 0; i < 8; i++) begin
            bus(1'b1, 12'h000, i << 4);
            repeat (3) @(posedge clk);
            chk("oe1", n1, i[1:0] == 2'h0);
            if (i[1:0] != 2'h0) chk("init1", p1, i[2]);
            cnt <= 16'h40;
            @(posedge clk);
            cnt <= 16'h0;
            repeat (3) @(posedge clk);
            e = i[1:0] == 2'h1 ? 0 : (i[1:0] == 2'h2 ? 1 : !i[2]);
            if (i[1:0] != 2'h0) chk("match1", p1, e);
        end
        $display("test compare done");
        // Capture codes on channel 2, rise then fall
        d2 <= 1'b1;
        for (i = 0; i < 4; i++) begin
            bus(1'b1, 12'h004, CODES[i*8 +: 8]);
            bus(1'b1, 12'h00C, 32'h0);
            cnt <= 16'h11 + i;
            v2 <= 1'b1;
            repeat (8) @(posedge clk);
            bus(1'b0, 12'h00C, 32'h0);
            e = (i != 2) ? 32'h11 + i : 32'h0;
            chk("rise2", rd, e);
            e = (i >= 2) ? 32'h22 + i : rd;
            cnt <= 16'h22 + i;
            v2 <= 1'b0;
            repeat (8) @(posedge clk);
            bus(1'b0, 12'h00C, 32'h0);
            chk("fall2", rd, e);
        end
        // Channel zero event into channel 1
        bus(1'b1, 12'h000, 32'hC0);
        cnt <= 16'h0ABC;
        evt <= 1'b1;
        @(posedge clk);
        evt <= 1'b0;
        repeat (3) @(posedge clk);
        bus(1'b0, 12'h008, 32'h0);
        chk("ext1", rd, 32'hABC);
        $display("test capture done");
        // Sticky capture flags, then cleared by the read
        bus(1'b0, 12'h010, 32'h0);
        chk("sticky", rd, 32'h3);
        bus(1'b0, 12'h010, 32'h0);
        chk("cleared", rd, 32'h0);
        // Channel 2 output: initial level 1, then released
        bus(1'b1, 12'h004, 32'h50);
        repeat (2) @(posedge clk);
        chk("oe2", n2, 32'h0);
        chk("init2", p2, 32'h1);
        bus(1'b0, 12'h010, 32'h0);
        chk("pins", rd, 32'h8);
        bus(1'b1, 12'h004, 32'h0);
        repeat (2) @(posedge clk);
        chk("off2", n2, 32'h1);
        $display("test status done");
        summarize();
    end
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        summarize();
    end
endmodule // timer_pin_b_io_select_test
